// ==== core/spd_eeprom_i2c_slave.sv ====
// two-wire slave of a 256 byte presence-detect memory with lower-half lock
// assumes rstn is the power-on reset; the bench resolves the sda wire
`timescale 1ns/1ps
`default_nettype none
`include "spd_eeprom_consts.svh"
module spd_eeprom_i2c_slave
  import spd_eeprom_pkg::*;
#(
  parameter logic [3:0] MEM_TYPE_ID = 4'h3, // arbitrary value
  parameter logic [3:0] PROT_TYPE_ID = 4'hc, // arbitrary value
  parameter int PROG_CYCLES = `T_WRITE_NS / `SYS_CLK_PERIOD_NS
)
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic scl_clk,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  input wire logic [`CS_W-1:0] chip_select_pins,
  input wire logic write_inhibit_pin,
  input wire logic lock_restore,
  output logic lock_state,
  output logic prog_busy
);

  localparam int PROG_W = $clog2(PROG_CYCLES + 1);
  localparam logic [PROG_W-1:0] PROG_LAST = PROG_W'(PROG_CYCLES - 1);
  // pin bundle: {tgl, cs[2:0], wc, sda, scl}
  logic [6:0] pins_in, meta_r, sync_r;
  logic [2:0] prev_r;
  logic [`DATA_W-1:0] rx_byte;
  logic bit_tgl;
  logic scl_s, sda_s, wc_s, bit_ev, scl_fall, start_ev, stop_ev;
  logic [`CS_W-1:0] cs_s;
  logic is_mem, is_prot, sel_ok, wr_ok;

  phase_type phase_r, phase_nxt;
  logic [`CNT_W-1:0] cnt_r, cnt_nxt;
  logic ack_r, ack_nxt, acked_r, acked_nxt, sda_oe_n_r, sda_oe_n_nxt;
  logic [`ADDR_W-1:0] addr_r, addr_nxt;
  logic [`DATA_W-1:0] tx_r, tx_nxt;
  logic prot_r, prot_nxt;
  logic [`PAGE_BYTES-1:0] valid_r, valid_nxt;
  logic [PROG_W-1:0] prog_cnt_r, prog_cnt_nxt;
  logic lock_r, lock_nxt, restored_r, restored_nxt, store, commit;
  logic [`DATA_W-1:0] latch_r [0:`PAGE_BYTES-1];
  logic [`DATA_W-1:0] latch_nxt [0:`PAGE_BYTES-1];
  logic [`DATA_W-1:0] mem_r [0:`MEM_DEPTH-1];
  logic [`DATA_W-1:0] mem_nxt [0:`MEM_DEPTH-1];

  spd_link_shifter link
  (
    .scl_clk(scl_clk),
    .rstn(rstn),
    .sda_i(sda_i),
    .rx_byte(rx_byte),
    .bit_tgl(bit_tgl)
  );

  assign pins_in = {bit_tgl, chip_select_pins, write_inhibit_pin, sda_i,
    scl_clk};

  // two stages on every pin and on the link toggle before any logic
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_r <= 7'h03;
      sync_r <= 7'h03;
      prev_r <= 3'h3;
    end
    else
    begin
      meta_r <= pins_in;
      sync_r <= meta_r;
      prev_r <= {sync_r[6], sync_r[1:0]};
    end
  end

  assign scl_s = sync_r[0];
  assign sda_s = sync_r[1];
  assign wc_s = sync_r[2];
  assign cs_s = sync_r[5:3];
  assign bit_ev = sync_r[6] ^ prev_r[2];
  assign scl_fall = prev_r[0] & ~scl_s;
  assign start_ev = scl_s & prev_r[0] & prev_r[1] & ~sda_s;
  assign stop_ev = scl_s & prev_r[0] & ~prev_r[1] & sda_s;

  // select byte: type in b7..b4, chip code b3..b1, rw in b0
  assign is_mem = rx_byte[7:4] == MEM_TYPE_ID;
  assign is_prot = rx_byte[7:4] == PROT_TYPE_ID;
  assign sel_ok = (rx_byte[3:1] == cs_s) & (is_mem | is_prot);
  // inhibit pin overrides everything; otherwise the lock blocks lock-register writes and memory addresses below 0x80
  assign wr_ok = ~wc_s & (prot_r ? ~lock_r : ~(lock_r & ~addr_r[7]));

  always_comb
  begin
    phase_nxt = phase_r;
    cnt_nxt = cnt_r;
    ack_nxt = ack_r;
    acked_nxt = acked_r;
    sda_oe_n_nxt = sda_oe_n_r;
    addr_nxt = addr_r;
    tx_nxt = tx_r;
    prot_nxt = prot_r;
    valid_nxt = valid_r;
    prog_cnt_nxt = prog_cnt_r;
    lock_nxt = lock_r;
    restored_nxt = 1'b1;
    store = 1'b0;
    commit = 1'b0;
    if (!restored_r)
      lock_nxt = lock_r | lock_restore;
    if (phase_r == PH_PROG)
    begin
      // bus is deaf until the page is committed
      sda_oe_n_nxt = 1'b1;
      if (prog_cnt_r == PROG_LAST)
      begin
        commit = 1'b1;
        valid_nxt = 16'h0000;
        phase_nxt = PH_IDLE;
        if (prot_r)
          lock_nxt = 1'b1;
      end
      else
        prog_cnt_nxt = prog_cnt_r + 1'b1;
    end
    else if (start_ev)
    begin
      phase_nxt = PH_SEL;
      cnt_nxt = 4'h0;
      ack_nxt = 1'b0;
      acked_nxt = 1'b0;
      sda_oe_n_nxt = 1'b1;
      valid_nxt = 16'h0000;
    end
    else if (stop_ev)
    begin
      phase_nxt = PH_IDLE;
      cnt_nxt = 4'h0;
      sda_oe_n_nxt = 1'b1;
      // only the clock right after an ack slot may precede the stop
      if (acked_r && cnt_r == `FIRST_BIT_DONE && phase_r == PH_WDATA &&
        valid_r != 16'h0000)
      begin
        phase_nxt = PH_PROG;
        prog_cnt_nxt = '0;
      end
    end
    else if (bit_ev && phase_r != PH_IDLE)
    begin
      cnt_nxt = cnt_r + 4'd1;
      if (cnt_r != 4'h0)
        acked_nxt = 1'b0;
      if (cnt_r == `ACK_SLOT)
      begin
        cnt_nxt = 4'h0;
        ack_nxt = 1'b0;
        if (phase_r == PH_RDATA)
        begin
          if (ack_r)
            tx_nxt = mem_r[addr_r];
          else if (rx_byte[0])
            phase_nxt = PH_IDLE;
          else
          begin
            addr_nxt = addr_r + 8'd1;
            tx_nxt = mem_r[addr_r + 8'd1];
          end
        end
        else
        begin
          acked_nxt = ack_r;
          if (!ack_r || phase_r == PH_SEL)
            phase_nxt = PH_IDLE;
        end
      end
      else if (cnt_r == `LAST_BIT)
      begin
        case (phase_r)
          PH_SEL:
          begin
            prot_nxt = is_prot;
            if (!sel_ok)
              phase_nxt = PH_IDLE;
            else if (rx_byte[0])
            begin
              // a lock-register read only answers with its ack
              ack_nxt = is_prot ? ~lock_r : 1'b1;
              if (is_mem)
                phase_nxt = PH_RDATA;
            end
            else
            begin
              ack_nxt = is_prot ? (~wc_s & ~lock_r) : 1'b1;
              phase_nxt = PH_ADDR;
            end
          end
          PH_ADDR:
          begin
            if (!prot_r)
              addr_nxt = rx_byte;
            ack_nxt = prot_r ? ~wc_s : 1'b1;
            phase_nxt = PH_WDATA;
          end
          PH_WDATA:
          begin
            ack_nxt = wr_ok;
            if (wr_ok && prot_r)
              valid_nxt[0] = 1'b1;
            else if (wr_ok)
            begin
              valid_nxt[addr_r[`PAGE_BITS-1:0]] = 1'b1;
              store = 1'b1;
              addr_nxt[`PAGE_BITS-1:0] = addr_r[`PAGE_BITS-1:0] + 4'd1;
            end
          end
          default:
          begin
          end
        endcase
      end
    end
    else if (scl_fall)
    begin
      // never drive high: release or pull low only
      if (phase_r == PH_IDLE)
        sda_oe_n_nxt = 1'b1;
      else if (cnt_r == `ACK_SLOT)
        sda_oe_n_nxt = ~ack_r;
      else if (phase_r == PH_RDATA)
        sda_oe_n_nxt = tx_r[3'd7 - cnt_r[2:0]];
      else
        sda_oe_n_nxt = 1'b1;
    end
  end

  // state seen by the bus; reset holds the line released
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      phase_r <= PH_IDLE;
      cnt_r <= 4'h0;
      ack_r <= 1'b0;
      acked_r <= 1'b0;
      sda_oe_n_r <= 1'b1;
      addr_r <= 8'h00;
      tx_r <= 8'hff;
      prot_r <= 1'b0;
      valid_r <= 16'h0000;
      prog_cnt_r <= '0;
      lock_r <= 1'b0;
      restored_r <= 1'b0;
    end
    else
    begin
      phase_r <= phase_nxt;
      cnt_r <= cnt_nxt;
      ack_r <= ack_nxt;
      acked_r <= acked_nxt;
      sda_oe_n_r <= sda_oe_n_nxt;
      addr_r <= addr_nxt;
      tx_r <= tx_nxt;
      prot_r <= prot_nxt;
      valid_r <= valid_nxt;
      prog_cnt_r <= prog_cnt_nxt;
      lock_r <= lock_nxt;
      restored_r <= restored_nxt;
    end
  end

  // page latch: later bytes of a rolled-over page overwrite earlier ones
  for (genvar g = 0; g < `PAGE_BYTES; g++)
  begin : latch_slot
    assign latch_nxt[g] = (store && addr_r[`PAGE_BITS-1:0] == 4'(g)) ?
      rx_byte : latch_r[g];
  end

  always_comb
  begin
    mem_nxt = mem_r;
    if (commit && !prot_r)
    begin
      for (int i = 0; i < `PAGE_BYTES; i++)
      begin
        if (valid_r[i])
          mem_nxt[{addr_r[7:4], 4'(i)}] = latch_r[i];
      end
    end
  end

  // array and latch model nonvolatile cells: no reset on purpose
  always_ff @(posedge sys_clk)
  begin
    mem_r <= mem_nxt;
    latch_r <= latch_nxt;
  end

  // margin: 400 kHz gives at least 30 system clocks per scl phase,
  // against about four clocks of synchroniser latency
  assign sda_o = 1'b0;
  assign sda_oe_n = sda_oe_n_r;
  assign lock_state = lock_r;
  assign prog_busy = (phase_r == PH_PROG);

endmodule
`default_nettype wire

// ==== common/spd_eeprom_consts.svh ====
// constants for the serial presence-detect memory slave
// assumes inclusion by bare name from design and bench files
`ifndef SPD_EEPROM_CONSTS_SVH
`define SPD_EEPROM_CONSTS_SVH

`define DATA_W 8
`define ADDR_W 8
`define MEM_DEPTH 256
`define CS_W 3
`define PAGE_BYTES 16
`define PAGE_BITS 4
`define CNT_W 4
`define LAST_BIT 4'd7
`define ACK_SLOT 4'd8
`define FIRST_BIT_DONE 4'd1
`define SCL_MAX_KHZ 400
`define SYS_CLK_PERIOD_NS 20
`define T_WRITE_NS 5000000

`endif

// ==== common/spd_eeprom_pkg.sv ====
// types shared by the presence-detect memory slave and its bench
// assumes nothing beyond a SystemVerilog compiler
package spd_eeprom_pkg;

  typedef enum logic [5:0] {
    PH_IDLE = 6'b000001,
    PH_SEL = 6'b000010,
    PH_ADDR = 6'b000100,
    PH_WDATA = 6'b001000,
    PH_RDATA = 6'b010000,
    PH_PROG = 6'b100000
  } phase_type;

endpackage

// ==== core/spd_link_shifter.sv ====
// link-side receive shifter, clocked by the serial clock itself
// assumes sda is stable around each rising edge of scl_clk
`timescale 1ns/1ps
`default_nettype none
`include "spd_eeprom_consts.svh"
module spd_link_shifter (
  input wire logic scl_clk,
  input wire logic rstn,
  input wire logic sda_i,
  output logic [`DATA_W-1:0] rx_byte,
  output logic bit_tgl
);

  logic [`DATA_W-1:0] shift_r;
  logic [`DATA_W-1:0] shift_nxt;
  logic tgl_r;
  logic tgl_nxt;

  // the toggle marks each sampled bit; the byte stays put until the
  // next rising edge, far longer than the system side needs to read it
  always_comb
  begin
    shift_nxt = {shift_r[`DATA_W-2:0], sda_i};
    tgl_nxt = ~tgl_r;
  end

  always_ff @(posedge scl_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      shift_r <= 8'h00;
      tgl_r <= 1'b0;
    end
    else
    begin
      shift_r <= shift_nxt;
      tgl_r <= tgl_nxt;
    end
  end

  assign rx_byte = shift_r;
  assign bit_tgl = tgl_r;

endmodule
`default_nettype wire

// ==== testbench/spd_eeprom_i2c_slave_assertions.sv ====
// assertions on the slave's pins
// assumes a bind from the bench top
`timescale 1ns/1ps
`default_nettype none
module spd_eeprom_i2c_slave_assertions #(
  parameter int PROG_CYCLES = 20
)
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic sda_i,
  input wire logic scl_clk,
  input wire logic sda_o,
  input wire logic sda_oe_n,
  input wire logic write_inhibit_pin,
  input wire logic lock_restore,
  input wire logic lock_state,
  input wire logic prog_busy
);
  int busy_n_r;
  int busy_n_nxt;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  always_comb busy_n_nxt = prog_busy ? busy_n_r + 1 : 0;
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn) busy_n_r <= 0;
    else busy_n_r <= busy_n_nxt;
  pull_only_a: assert property (sda_o == 1'b0)
    else $error("sda driven high");
  busy_deaf_a: assert property (prog_busy |-> sda_oe_n)
    else $error("ack while busy");
  lock_sticky_a: assert property (lock_state |=> lock_state)
    else $error("lock cleared");
  lock_load_a: assert property (
    $rose(rstn) |=> lock_state == $past(lock_restore))
    else $error("lock not restored");
  reset_quiet_a: assert property (
    $rose(rstn) |-> sda_oe_n && !prog_busy) else $error("active in reset");
  prog_len_a: assert property (
    $fell(prog_busy) |-> busy_n_r == PROG_CYCLES) else $error("busy length");
  inhibit_prog_a: assert property (
    $rose(prog_busy) |-> !write_inhibit_pin) else $error("inhibited write");
  stop_prog_a: assert property (
    $rose(prog_busy) |-> scl_clk && sda_i) else $error("write without stop");
  cover property ($rose(prog_busy));
  cover property ($fell(sda_oe_n) ##[1:200] $rose(sda_oe_n));
  cover property ($rose(lock_state));
endmodule
`default_nettype wire

// ==== testbench/spd_i2c_master.sv ====
// two-wire bus master model: drives scl and its side of sda
// assumes the bench resolves sda; steps on falling clk edges
`timescale 1ns/1ps
`default_nettype none
module spd_i2c_master #(
  parameter int HALF = 64
)
(
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_m
);
  logic r;
  initial
  begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  // 64 cycles per half keeps scl near 390 kHz
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic start_c;
    sda_m = 1'b1;
    wt(HALF / 2);
    scl = 1'b1;
    wt(HALF);
    sda_m = 1'b0;
    wt(HALF);
    scl = 1'b0;
    wt(HALF / 2);
  endtask
  // data moves only in mid-low, never beside an scl edge
  task automatic bitx(input logic b, output logic s);
    sda_m = b;
    wt(HALF / 2);
    scl = 1'b1;
    wt(HALF);
    s = sda;
    scl = 1'b0;
    wt(HALF / 2);
  endtask
  task automatic stop_c;
    sda_m = 1'b0;
    wt(HALF / 2);
    scl = 1'b1;
    wt(HALF);
    sda_m = 1'b1;
    wt(HALF);
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    ack = !r;
  endtask
  task automatic rbyte(input logic more, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(!more, r);
  endtask
endmodule
`default_nettype wire

// ==== testbench/spd_eeprom_i2c_slave_tb.sv ====
// bench top: slave, master model, reference memory, checker bind
// assumes sda idles high through a pull-up
`timescale 1ns/1ps
`default_nettype none
`include "spd_eeprom_consts.svh"
module spd_eeprom_i2c_slave_tb
  import spd_eeprom_pkg::*;
;
  localparam int PROG = 2000;
  localparam logic [3:0] MEM = 4'h3;
  localparam logic [3:0] PROT = 4'hc;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic inh = 1'b0;
  logic nv_lock = 1'b0;
  logic [`CS_W-1:0] cs = 3'h0;
  logic scl, sda_m, sda_o, sda_oe_n, lock_state, prog_busy, ack;
  logic [7:0] d, a;
  logic [7:0] mem [256];
  int n_mismatch = 0;
  int checks = 0;
  wire logic sda = sda_m & (sda_oe_n | sda_o);
  always #10 sys_clk = ~sys_clk;
  // stands in for the nonvolatile lock cell
  always @(posedge sys_clk) if (lock_state === 1'b1) nv_lock <= 1'b1;
  spd_i2c_master m (.clk(sys_clk), .sda(sda), .scl(scl), .sda_m(sda_m));
  spd_eeprom_i2c_slave #(.MEM_TYPE_ID(MEM), .PROT_TYPE_ID(PROT),
    .PROG_CYCLES(PROG)) dut (.sys_clk(sys_clk), .rstn(rstn),
    .scl_clk(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .chip_select_pins(cs), .write_inhibit_pin(inh),
    .lock_restore(nv_lock), .lock_state(lock_state),
    .prog_busy(prog_busy));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
    input string what);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic sel(input logic [3:0] ty, input logic [2:0] c,
    input logic rd, input logic exp);
    m.start_c;
    m.wbyte({ty, c, rd}, ack);
    chk(ack, exp, "select ack");
  endtask
  task automatic wr(input logic [3:0] ty, input logic [7:0] ad,
    input int n, input logic ok);
    sel(ty, cs, 1'b0, 1'b1);
    m.wbyte(ad, ack);
    chk(ack, 1'b1, "addr ack");
    for (int i = 0; i < n; i++)
    begin
      d = 8'($urandom);
      m.wbyte(d, ack);
      chk(ack, ok, "data ack");
      if (ok && ty == MEM) mem[{ad[7:4], ad[3:0] + 4'(i)}] = d;
    end
    m.stop_c;
  endtask
  task automatic settle;
    repeat (PROG + 20) @(negedge sys_clk);
    chk(prog_busy, 1'b0, "busy");
  endtask
  task automatic rd(input logic [7:0] ad, input int n);
    sel(MEM, cs, 1'b0, 1'b1);
    m.wbyte(ad, ack);
    sel(MEM, cs, 1'b1, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      m.rbyte(i < n - 1, d);
      chk(d, mem[8'(ad + i)], "read data");
    end
    m.stop_c;
  endtask
  initial
  begin
    void'($urandom(32'ha96f));
    repeat (10) @(negedge sys_clk);
    rstn = 1'b1;
    repeat (5) @(negedge sys_clk);
    chk(sda_oe_n, 1'b1, "idle oe");
    cs = 3'($urandom);
    a = 8'h80 | 8'($urandom);
    wr(MEM, a, 1, 1'b1);
    sel(MEM, cs, 1'b0, 1'b0);
    m.stop_c;
    settle;
    rd(a, 1);
    a = 8'h9e;
    wr(MEM, a, 4, 1'b1);
    settle;
    rd(a, 2);
    rd(8'h90, 2);
    sel(MEM ^ 4'h8, cs, 1'b0, 1'b0);
    m.stop_c;
    sel(MEM, ~cs, 1'b1, 1'b0);
    m.stop_c;
    cs = ~cs;
    rd(a, 1);
    inh = 1'b1;
    wr(MEM, a, 1, 1'b0);
    sel(PROT, cs, 1'b0, 1'b0);
    m.stop_c;
    settle;
    inh = 1'b0;
    rd(a, 1);
    a = {1'b0, 7'($urandom)};
    wr(MEM, a, 1, 1'b1);
    settle;
    wr(PROT, 8'h00, 1, 1'b1);
    settle;
    chk(lock_state, 1'b1, "lock set");
    wr(MEM, a, 1, 1'b0);
    settle;
    rstn = 1'b0;
    sel(MEM, cs, 1'b0, 1'b0);
    m.stop_c;
    rstn = 1'b1;
    repeat (5) @(negedge sys_clk);
    chk(lock_state, 1'b1, "lock kept");
    wr(MEM, a, 1, 1'b0);
    settle;
    rd(a, 1);
    give_verdict;
  end
  initial
  begin
    // the full sequence needs about 85000 clocks
    repeat (95000) @(posedge sys_clk);
    n_mismatch++;
    give_verdict;
  end
endmodule
bind spd_eeprom_i2c_slave spd_eeprom_i2c_slave_assertions #(
  .PROG_CYCLES(PROG_CYCLES)) chk_i (.sys_clk(sys_clk), .rstn(rstn),
  .sda_i(sda_i), .scl_clk(scl_clk), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
  .write_inhibit_pin(write_inhibit_pin), .lock_restore(lock_restore),
  .lock_state(lock_state), .prog_busy(prog_busy));
`default_nettype wire
